/* File: hdl/tamper_pkg.sv */
// Holds the shared constants and carrier types for the tamper mux block.
// Assumes a 250 MHz aclk and an AXI4-Lite master for register access.
package tamper_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 250_000_000; // Core clock rate
  localparam int unsigned CLK_OFF_MS    = 30;          // Clocks held off
  localparam int unsigned DIG_RST_MS    = 125;         // Digital reset hold
  localparam int unsigned PULSE_W_US    = 31250;       // Divided pulse width
  localparam int unsigned CLK_OFF_CYC   = CLK_HZ / 1000 * CLK_OFF_MS;
  localparam int unsigned DIG_RST_CYC   = CLK_HZ / 1000 * DIG_RST_MS;
  localparam int unsigned PULSE_W_CYC   = CLK_HZ / 1000 / 1000 * PULSE_W_US;

  // ************************************************************
  // Multiplex schedule, in line periods
  // ************************************************************
  localparam logic [6:0] MUX_FRAME      = 7'h40;  // 64 periods per frame
  localparam logic [6:0] MUX_HALF       = 7'h20;  // 32:32 split
  localparam logic [6:0] MUX_LONG       = 7'h3c;  // 60 periods
  localparam logic [6:0] MUX_SHORT      = 7'h04;  // 4 periods
  localparam logic [6:0] EVAL_LEAD      = 7'h04;  // Window opens 4 early
  localparam logic [6:0] EVAL_LEN       = 7'h08;  // Window lasts 8
  localparam logic [2:0] CONSEC_HITS    = 3'h4;   // Hits before tamper

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [3:0] REG_CTRL       = 4'h0;   // Configuration
  localparam logic [3:0] REG_STAT       = 4'h4;   // Status
  localparam logic [3:0] REG_PHASE      = 4'h8;   // Phase trim
  localparam logic [3:0] REG_PERIOD     = 4'hc;   // Line period in cycles
  localparam logic [31:0] PERIOD_RST    = 32'h004c4b40; // 20 ms default
  localparam logic [31:0] PERIOD_MIN    = 32'h003d0900; // 16 ms
  localparam logic [31:0] PERIOD_MAX    = 32'h005b8d80; // 24 ms
  localparam logic [3:0] PHASE_RST      = 4'h0;   // No compensation
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;

  // Configuration bits held in the control register
  typedef struct packed {
    logic       threshold_sel;  // 0: 12.5 %, 1: 6.25 %
    logic [1:0] divider_sel;    // Pulse divider select
    logic       rate_sel;       // 1: divided output
    logic       clk_range;      // 0: 4 MHz band, 1: 8 MHz band
  } ctrl_t;
  localparam ctrl_t CTRL_RST = '0;

  // Tamper machine states
  typedef enum logic [1:0] {
    ST_NORMAL  = 2'b00,
    ST_TAMP_P  = 2'b01,  // Primary higher, 60:4
    ST_TAMP_S  = 2'b10   // Secondary higher, 4:60
  } tamper_state_t;

  // Reset sequencer phases
  typedef enum logic [1:0] {
    RS_CLKOFF  = 2'b00,
    RS_DIGRST  = 2'b01,
    RS_RUN     = 2'b10
  } rst_phase_t;

endpackage

/* File: hdl/tamper_mux_and_energy_pulse.sv */
// Holds the tamper multiplexer, phase delay, reset sequencer and pulse out.
// Assumes an AXI4-Lite master on aclk and synchronous pins for the rest.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module tamper_mux_and_energy_pulse
  import tamper_pkg::*;
#(
  parameter int unsigned CLK_OFF_CYCLES = tamper_pkg::CLK_OFF_CYC,
  parameter int unsigned DIG_RST_CYCLES = tamper_pkg::DIG_RST_CYC,
  parameter int unsigned PULSE_CYCLES   = tamper_pkg::PULSE_W_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        line_zero_cross,   // Line period marker pin
  input  wire logic        sd_stuck,          // Sigma-delta stuck flag
  input  wire logic        no_load_flag,      // No-load condition
  input  wire logic        energy_pulse,      // Internal energy pulse
  input  wire logic        primary_tick,      // Primary energy quantum
  input  wire logic        secondary_tick,    // Secondary energy quantum
  input  wire logic        volt_sample,       // Voltage path stream
  output logic             volt_delayed,      // Compensated voltage path
  output logic             chan_select_q,     // 1: secondary in use
  output logic             tamper_out_pin,    // Low when tampered
  output logic             pulse_out,         // Pulse output pin
  output logic             analog_enable,     // Clocks and buffers on
  output logic             clk_div_sel        // 1: halve core clock
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Two stages per pin; stage one feeds only stage two
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  always_ff @(posedge aclk) begin
    sync1_q <= {line_zero_cross, sd_stuck, no_load_flag,
                energy_pulse, primary_tick, secondary_tick};
    sync2_q <= sync1_q;
  end
  wire zc_s   = sync2_q[5];
  wire stk_s  = sync2_q[4];
  wire nl_s   = sync2_q[3];
  wire ep_s   = sync2_q[2];
  wire pt_s   = sync2_q[1];
  wire st_s   = sync2_q[0];

  // ************************************************************
  // Reset sequencer
  // ************************************************************
  rst_phase_t  rphase_q;     // Power-up phase
  logic [31:0] rcnt_q;       // Phase timer
  wire         run = (rphase_q == RS_RUN);
  wire         rst_d = !aresetn || !run;  // Digital reset
  // Clocks off 30 ms, then logic held until 125 ms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rphase_q <= RS_CLKOFF;
      rcnt_q   <= '0;
    end else begin
      case (rphase_q)
        RS_CLKOFF: begin
          rcnt_q <= rcnt_q + 32'h1;
          if (rcnt_q >= CLK_OFF_CYCLES - 1) rphase_q <= RS_DIGRST;
        end
        RS_DIGRST: begin
          rcnt_q <= rcnt_q + 32'h1;
          if (rcnt_q >= DIG_RST_CYCLES - 1) rphase_q <= RS_RUN;
        end
        RS_RUN:  rcnt_q <= rcnt_q;
        default: rphase_q <= RS_CLKOFF;
      endcase
    end
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  ctrl_t       ctrl_q;       // Shadow configuration, cleared on reset
  logic [3:0]  phase_trim_setting_q;
  logic [31:0] period_q;     // Measured line period in cycles
  logic        tamper_flag_q;
  tamper_state_t st_q;
  logic        aw_hold_q, w_hold_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  // Both halves held, no response pending: commit
  wire do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire wr_ctrl  = do_wr && (aw_addr_q == REG_CTRL) && w_strb_q[0];
  wire wr_phase = do_wr && (aw_addr_q == REG_PHASE) && w_strb_q[0];
  wire wr_ok    = (aw_addr_q == REG_CTRL) || (aw_addr_q == REG_PHASE);
  wire rd_ok    = (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rd_mux =
    (s_axi_araddr == REG_CTRL)   ? {27'h0, ctrl_q} :
    (s_axi_araddr == REG_STAT)   ? {27'h0, run, st_q, chan_select_q,
                                    tamper_flag_q} :
    (s_axi_araddr == REG_PHASE)  ? {28'h0, phase_trim_setting_q} :
    (s_axi_araddr == REG_PERIOD) ? period_q : 32'h0;
  // Write channels taken independently, in either order
  always_ff @(posedge aclk) begin
    if (rst_d) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = run && !aw_hold_q;
  assign s_axi_wready  = run && !w_hold_q;
  assign s_axi_arready = run && !s_axi_rvalid;
  // Read answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (rst_d) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Shadow configuration cleared by any reset
  always_ff @(posedge aclk) begin
    if (rst_d) begin
      ctrl_q <= CTRL_RST;
      phase_trim_setting_q <= PHASE_RST;
    end else begin
      if (wr_ctrl)  ctrl_q <= w_data_q[4:0];
      if (wr_phase) phase_trim_setting_q <= w_data_q[3:0];
    end
  end

  // ************************************************************
  // Clock range and analog enable
  // ************************************************************
  // Band bit: halve the core clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_div_sel   <= 1'b0;
      analog_enable <= 1'b0;
    end else begin
      clk_div_sel   <= ctrl_q.clk_range;
      analog_enable <= (rphase_q != RS_CLKOFF);
    end
  end

  // ************************************************************
  // Line period counter
  // ************************************************************
  logic        zc_q;
  logic [31:0] pcnt_q;
  logic [6:0]  per_q;        // Period index in 64-period frame
  wire         zc_rise = zc_s && !zc_q;
  // Out-of-range period measurement disables tamper logic
  wire         per_bad = (period_q < PERIOD_MIN) || (period_q > PERIOD_MAX);
  // Whole line cycles drive the schedule
  always_ff @(posedge aclk) begin
    if (rst_d) begin
      zc_q     <= 1'b0;
      pcnt_q   <= '0;
      period_q <= PERIOD_RST;
      per_q    <= '0;
    end else begin
      zc_q <= zc_s;
      if (zc_rise) begin
        period_q <= pcnt_q;
        pcnt_q   <= '0;
        per_q    <= (per_q == MUX_FRAME - 7'h1) ? 7'h0 : per_q + 7'h1;
      end else if (pcnt_q != 32'hffffffff) begin
        pcnt_q <= pcnt_q + 32'h1;
      end
    end
  end

  // ************************************************************
  // Multiplex schedule and evaluation window
  // ************************************************************
  // Switchover point depends on state
  wire [6:0] switch_at = (st_q == ST_TAMP_P) ? MUX_LONG :
                         (st_q == ST_TAMP_S) ? MUX_SHORT : MUX_HALF;
  wire       win_open  = (per_q >= switch_at - EVAL_LEAD) &&
                         (per_q <  switch_at - EVAL_LEAD + EVAL_LEN);
  wire       in_b      = (per_q >= switch_at);
  wire       win_end   = zc_rise &&
                         (per_q == switch_at - EVAL_LEAD + EVAL_LEN - 7'h1);
  // Tamper keeps the higher channel even across the gap
  wire       use_sec   = (st_q == ST_TAMP_S) ? 1'b1 :
                         (st_q == ST_TAMP_P) ? 1'b0 : in_b;
  always_ff @(posedge aclk) begin
    if (!aresetn) chan_select_q <= 1'b0;
    else          chan_select_q <= use_sec;
  end

  // ************************************************************
  // Samples A and B and criterion
  // ************************************************************
  logic [23:0] samp_a_q, samp_b_q;
  logic        pt_q, st_q2;
  wire         pt_ev = pt_s && !pt_q;
  wire         st_ev = st_s && !st_q2;
  // Gap samples the other channel too
  always_ff @(posedge aclk) begin
    if (rst_d) begin
      pt_q <= 1'b0;
      st_q2 <= 1'b0;
      samp_a_q <= '0;
      samp_b_q <= '0;
    end else begin
      pt_q  <= pt_s;
      st_q2 <= st_s;
      if (win_end) begin
        samp_a_q <= '0;
        samp_b_q <= '0;
      end else if (win_open) begin
        if (!in_b && pt_ev) samp_a_q <= samp_a_q + 24'h1;
        if (in_b && st_ev)  samp_b_q <= samp_b_q + 24'h1;
      end
    end
  end
  wire [24:0] sum_ab = {1'b0, samp_a_q} + {1'b0, samp_b_q};
  wire [23:0] diff   = (samp_a_q > samp_b_q) ? samp_a_q - samp_b_q :
                                               samp_b_q - samp_a_q;
  // Average times 12.5 % is sum/16, times 6.25 % is sum/32
  wire [24:0] thr    = ctrl_q.threshold_sel ? (sum_ab >> 5) : (sum_ab >> 4);
  wire        tamper_threshold_select   = ({1'b0, diff} > thr);
  wire        a_high = (samp_a_q > samp_b_q);

  // ************************************************************
  // Tamper state machine
  // ************************************************************
  logic [2:0] hits_q;
  wire        inhibit = per_bad || stk_s || nl_s;
  always_ff @(posedge aclk) begin
    if (rst_d) begin
      st_q   <= ST_NORMAL;
      hits_q <= '0;
    end else if (inhibit) begin
      st_q   <= ST_NORMAL;
      hits_q <= '0;
    end else if (win_end) begin
      case (st_q)
        ST_NORMAL: begin
          if (!tamper_threshold_select) hits_q <= '0;
          else if (hits_q == CONSEC_HITS - 3'h1) begin
            hits_q <= '0;
            st_q   <= a_high ? ST_TAMP_P : ST_TAMP_S;
          end else hits_q <= hits_q + 3'h1;
        end
        ST_TAMP_P, ST_TAMP_S: begin
          if (!tamper_threshold_select) st_q <= ST_NORMAL;
          else st_q <= a_high ? ST_TAMP_P : ST_TAMP_S;
        end
        default: st_q <= ST_NORMAL;
      endcase
    end
  end
  // Flag and active-low pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tamper_flag_q  <= 1'b0;
      tamper_out_pin <= 1'b1;
    end else begin
      tamper_flag_q  <= (st_q != ST_NORMAL);
      tamper_out_pin <= (st_q == ST_NORMAL);
    end
  end

  // ************************************************************
  // Phase compensation delay line
  // ************************************************************
  // Zero trim taps the first stage: no added shift
  // Each code adds one sample of delay, linear steps
  logic [15:0] vdly_q;
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_dly
      always_ff @(posedge aclk) begin
        if (rst_d) vdly_q[g] <= 1'b0;
        else       vdly_q[g] <= (g == 0) ? volt_sample :
                                vdly_q[(g > 0) ? g - 1 : 0];
      end
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) volt_delayed <= 1'b0;
    else          volt_delayed <= vdly_q[phase_trim_setting_q];
  end

  // ************************************************************
  // Energy to pulse output
  // ************************************************************
  logic       ep_q;
  logic [7:0] div_q;
  logic [31:0] pw_q;         // Remaining width of divided pulse
  wire        ep_rise = ep_s && !ep_q;
  wire [7:0]  div_top = (ctrl_q.divider_sel == 2'h0) ? 8'd63  :
                        (ctrl_q.divider_sel == 2'h1) ? 8'd127 :
                        (ctrl_q.divider_sel == 2'h2) ? 8'd31  : 8'd255;
  // Divide by selected ratio
  always_ff @(posedge aclk) begin
    if (rst_d) begin
      ep_q  <= 1'b0;
      div_q <= '0;
      pw_q  <= '0;
    end else begin
      ep_q <= ep_s;
      if (ep_rise && ctrl_q.rate_sel) begin
        div_q <= (div_q >= div_top) ? 8'h0 : div_q + 8'h1;
        if (div_q >= div_top) pw_q <= PULSE_CYCLES;
      end
      if (pw_q != 32'h0 && !(ep_rise && div_q >= div_top)) begin
        pw_q <= pw_q - 32'h1;
      end
    end
  end
  // Undivided mode passes the 50 % energy pulse straight
  always_ff @(posedge aclk) begin
    if (!aresetn) pulse_out <= 1'b0;
    else pulse_out <= ctrl_q.rate_sel ? (pw_q != 32'h0) : ep_s;
  end

endmodule

/* File: sim/tamper_asserts.sv */
// Checker for the tamper mux block, watching its top-level ports only.
// Assumes one clock; sequencer counts come from the bind.
`timescale 1ns/100ps
module tamper_asserts #(
  parameter int unsigned CLK_OFF_CYCLES = 20,
  parameter int unsigned DIG_RST_CYCLES = 50
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sd_stuck,
  input wire logic        no_load_flag,
  input wire logic        tamper_out_pin,
  input wire logic        pulse_out,
  input wire logic        analog_enable,
  input wire logic        clk_div_sel
);
  // Cycles since release, saturating
  logic [9:0] up_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      up_q <= 10'h000;
    else if (up_q != 10'h3ff)
      up_q <= up_q + 10'h001;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ************************************************************
  // Start-up sequencing
  // ************************************************************
  property p_tamp_early;
    up_q < DIG_RST_CYCLES |-> tamper_out_pin;
  endproperty
  a_tamp_early: assert property (p_tamp_early)
    else $error("tamper pin low during start-up");
  property p_pulse_early;
    up_q < DIG_RST_CYCLES |-> !pulse_out;
  endproperty
  a_pulse_early: assert property (p_pulse_early)
    else $error("pulse pin active during start-up");
  property p_div_early;
    up_q < DIG_RST_CYCLES |-> !clk_div_sel;
  endproperty
  a_div_early: assert property (p_div_early)
    else $error("clock range not cleared by reset");
  property p_analog_off;
    up_q < CLK_OFF_CYCLES |-> !analog_enable;
  endproperty
  a_analog_off: assert property (p_analog_off)
    else $error("analog enabled too early");
  property p_analog_on;
    up_q > CLK_OFF_CYCLES + 3 |-> analog_enable;
  endproperty
  a_analog_on: assert property (p_analog_on)
    else $error("analog not enabled after clock-off phase");
  property p_bus_held;
    up_q < DIG_RST_CYCLES |-> !s_axi_awready && !s_axi_arready;
  endproperty
  a_bus_held: assert property (p_bus_held)
    else $error("bus accepted during digital reset");
  // ************************************************************
  // Register bus and tamper inhibit
  // ************************************************************
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_inhibit;
    (no_load_flag || sd_stuck) [*6] |-> tamper_out_pin;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("tamper shown while inhibited");
endmodule
bind tamper_mux_and_energy_pulse tamper_asserts #(
  .CLK_OFF_CYCLES(CLK_OFF_CYCLES),
  .DIG_RST_CYCLES(DIG_RST_CYCLES)
) chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sd_stuck,
  .no_load_flag, .tamper_out_pin, .pulse_out, .analog_enable, .clk_div_sel);

/* File: sim/meter_model.sv */
// Front-end model: energy pulse source, channel quanta and line marker.
// Assumes send() is called just after a rising edge.
`timescale 1ns/100ps
module meter_model #(
  parameter int unsigned LINE_CYC = 5000000  // 20 ms line period
) (
  input  wire logic aclk,
  output logic      energy_pulse,
  output logic      primary_tick,
  output logic      secondary_tick,
  output logic      line_zero_cross
);
  int unsigned t_q = 0;  // Free-running cycle count
  initial energy_pulse = 1'b0;
  always @(posedge aclk) t_q <= t_q + 1;
  // Quanta at two rates; the line marker rises once per line period
  assign primary_tick    = t_q[1];
  assign secondary_tick  = t_q[2];
  assign line_zero_cross = (t_q % LINE_CYC) >= LINE_CYC / 2;
  // Square energy train of n periods, half cycles high then low
  task automatic send(input int n, input int half);
    repeat (n) begin
      energy_pulse <= 1'b1;
      repeat (half) @(posedge aclk);
      energy_pulse <= 1'b0;
      repeat (half) @(posedge aclk);
    end
  endtask
endmodule

/* File: sim/tamper_mux_and_energy_pulse_bench.sv */
// Self-checking bench for the tamper mux and energy pulse block.
// Assumes small sequencer counts and the meter_model front end.
`timescale 1ns/100ps
module tamper_mux_and_energy_pulse_bench;
  import tamper_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sd_stuck;
  logic        no_load_flag, volt_sample, volt_delayed, chan_select_q;
  logic        tamper_out_pin, pulse_out, analog_enable, clk_div_sel;
  logic        line_zero_cross, energy_pulse, primary_tick, secondary_tick;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd, c;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];  // Expected {resp, data} of bus answers
  string       nm_q[$];
  int          pw_q[$];   // Expected pulse widths
  logic        vq[$];     // Voltage bits awaiting echo
  int          v_lag, n_errors, samples_checked, pw_cnt, i;
  int          div_tab[4] = '{64, 128, 32, 256};
  tamper_mux_and_energy_pulse #(.CLK_OFF_CYCLES(20), .DIG_RST_CYCLES(50),
    .PULSE_CYCLES(10)) DUT (.*);
  meter_model partner (.aclk, .energy_pulse, .primary_tick,
    .secondary_tick, .line_zero_cross);
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic give_up();
    n_errors++;
    wrap_up();
  endtask
  // Holds ready high until the answer is seen
  task automatic answer(input bit wr);
    int k;
    if (wr) s_axi_bready <= 1'b1;
    else s_axi_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (wr ? s_axi_bvalid : s_axi_rvalid) break;
    end
    if (k == 100) give_up();
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           input logic [1:0] r, input string what);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    exp_q.push_back({r, 32'h0});
    nm_q.push_back(what);
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (k < 100 && (s_axi_awvalid || s_axi_wvalid));
    if (k == 100) give_up();
    answer(1);
  endtask
  task automatic axi_read(input logic [3:0] a, input logic [33:0] want,
                          input string what);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    exp_q.push_back(want);
    nm_q.push_back(what);
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_arready) break;
    end
    if (k == 100) give_up();
    s_axi_arvalid <= 1'b0;
    answer(0);
  endtask
  // ************************************************************
  // Monitors: each result takes the oldest note
  // ************************************************************
  always @(posedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      check(nm_q.pop_front(), s_axi_bvalid ? {s_axi_bresp, 32'h0} :
            {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  // Width measured at the fall; a surplus pulse is a miss
  always @(posedge aclk) begin
    if (pulse_out === 1'b1)
      pw_cnt <= pw_cnt + 1;
    else if (pw_cnt != 0) begin
      pw_cnt <= 0;
      check("pulse width", 34'(pw_cnt),
            34'(pw_q.size() ? pw_q.pop_front() : 0));
    end
  end
  // 1 ns late so this edge's note is queued
  always @(posedge aclk) begin
    #1;
    if (vq.size() == v_lag + 1)
      check("delayed voltage", 34'(volt_delayed), 34'(vq.pop_front()));
  end
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    {rnd, n_errors, samples_checked, pw_cnt, v_lag} = {32'h61, 96'h0, 32'd99};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, sd_stuck, no_load_flag, volt_sample} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 200 && s_axi_arready !== 1'b1; i++) @(posedge aclk);
    if (i == 200) give_up();
    // Reset values and unmapped places
    axi_read(REG_CTRL, 34'h0, "ctrl reset");
    axi_read(REG_STAT, 34'h10, "status reset");
    axi_read(REG_PHASE, 34'h0, "phase reset");
    axi_read(REG_PERIOD, {2'b00, PERIOD_RST}, "period reset");
    axi_read(4'h2, {RESP_SLVERR, 32'h0}, "unmapped read");
    axi_write(4'h2, 32'hffffffff, RESP_SLVERR, "unmapped write");
    check("tamper pin", 34'(tamper_out_pin), 34'h1);
    check("channel", 34'(chan_select_q), 34'h0);
    $display("test registers done");
    // Random control word, read back and mirrored on the clock pin
    c = xs() & 32'h0000001f;
    axi_write(REG_CTRL, c, RESP_OKAY, "ctrl write");
    axi_read(REG_CTRL, {2'b00, c}, "ctrl readback");
    check("clock range", 34'(clk_div_sel), 34'(c[0]));
    no_load_flag <= 1'b1;
    repeat (10) @(posedge aclk);
    no_load_flag <= 1'b0;
    check("inhibited pin", 34'(tamper_out_pin), 34'h1);
    $display("test control done");
    // Phase delay: no trim, full trim, random trim
    for (i = 0; i < 3; i++) begin
      c = (i == 0) ? 32'h0 : (i == 1) ? 32'hf : (xs() & 32'hf);
      axi_write(REG_PHASE, c, RESP_OKAY, "phase write");
      v_lag = c + 2;
      repeat (40) begin
        @(posedge aclk);
        c = xs();
        volt_sample <= c[0];
        vq.push_back(c[0]);
      end
      v_lag = 99;
      vq.delete();
    end
    $display("test phase done");
    // Divided output: two pulses per two ratios of edges
    for (i = 0; i < 4; i++) begin
      axi_write(REG_CTRL, {28'h0, i[1:0], 2'b10}, RESP_OKAY, "ctrl div");
      repeat (2) pw_q.push_back(10);
      partner.send(2 * div_tab[i], 4);
      repeat (20) @(posedge aclk);
      check("pulses left", 34'(pw_q.size()), 34'h0);
    end
    // Undivided output follows the energy train one for one
    axi_write(REG_CTRL, 32'h0, RESP_OKAY, "ctrl direct");
    repeat (6) pw_q.push_back(4);
    partner.send(6, 4);
    repeat (10) @(posedge aclk);
    check("pulses left", 34'(pw_q.size()), 34'h0);
    $display("test pulse done");
    wrap_up();
  end
endmodule
